// file: rtl/f2i_defines.svh
// Constants of the float-to-integer convert and status block.
// Assumes it is included by bare name, once per compilation unit.
// Notes on behaviour
// - First test value is biased exponent minus octal 201.
// - Negative first test: error, zero flag set, zeros delivered.
// - Subtract 16 (short) or 32 (long); zero or more: error, zeros.
// - Second test negative, not minus one: convert without overflow.
// - Second test minus one: keep converting, final sign check decides.
// - Right shift count is width plus 0o201 minus exponent minus one.
// - Fraction bits always truncated, whatever the truncate flag says.
// - Positive result sent as is; negative source is two's-complemented.
// - Result MSB differing from sign: error, trap if trap enabled.
// - Load status copies 16 bits into the status word.
// - Store status returns all 16 status bits.
// - Store exception, register mode: only the exception code.
// - Memory mode: code word then address; code uses low 4 bits.
// - Copy condition codes passes carry, zero, overflow, negative.
// - Single mode clears status bit 7.
// - Double mode sets status bit 7.
// - Short integer mode clears status bit 6.
// - Long integer mode sets status bit 6.
`ifndef F2I_DEFINES_SVH
`define F2I_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define F2I_A_STATUS 5'h00
`define F2I_A_SRC_HI 5'h04
`define F2I_A_SRC_LO 5'h08
`define F2I_A_CMD 5'h0C
`define F2I_A_RESULT 5'h10
`define F2I_A_IADDR 5'h14
`define F2I_A_EXC 5'h18

// ----------------------------------------------------------------
// Status word fields
// ----------------------------------------------------------------
`define F2I_ST_ERR 15
`define F2I_ST_TRAP_EN 10
`define F2I_ST_DP 7
`define F2I_ST_LI 6
`define F2I_ST_TRUNC 5
`define F2I_ST_N 3
`define F2I_ST_Z 2
`define F2I_ST_V 1
`define F2I_ST_C 0
`define F2I_ST_RESET 16'h0000

// ----------------------------------------------------------------
// Commands (low nibble of the command word), memory-mode bit
// ----------------------------------------------------------------
`define F2I_OP_CONVERT 4'h1
`define F2I_OP_SINGLE 4'h2
`define F2I_OP_DOUBLE 4'h3
`define F2I_OP_SHORTI 4'h4
`define F2I_OP_LONGI 4'h5
`define F2I_OP_COPYCC 4'h6
`define F2I_OP_STEXC 4'h7
`define F2I_CMD_MEM 8

// ----------------------------------------------------------------
// Conversion constants
// ----------------------------------------------------------------
`define F2I_EXP_BIAS1 9'h081
`define F2I_SHORT_SPAN 9'h010
`define F2I_LONG_SPAN 9'h020
`define F2I_SHORT_W 6'h10
`define F2I_LONG_W 6'h20
`define F2I_EC_CONVERT 4'h6
`define F2I_RESP_OK 2'h0
`define F2I_RESP_ERR 2'h2

`endif

// file: rtl/f2i_pkg.sv
// Types shared by the float-to-integer convert and status block.
// Assumes the defines header is compiled alongside.
package f2i_pkg;

    typedef struct packed {
        logic [31:0] value;
        logic err;
        logic below_one;
    } f2i_conv_t;

    typedef struct packed {
        logic valid;
        logic [2:0] idx;
    } f2i_dec_t;

endpackage : f2i_pkg

// file: rtl/f2i_top.sv
// Float-to-integer store conversion and status word, AXI4-Lite slave.
// Assumes one clock, a host that loads the source and issues commands
// through the command register, and a host that takes TRAP_O.
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "f2i_defines.svh"

module f2i_top
    import f2i_pkg::*;
#(
    parameter int ADDR_W = 5
)
(
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    output logic [3:0] CPU_CC_O,
    output logic CC_VALID_O,
    output logic TRAP_O
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic f2i_dec_t f2i_decode(input logic [ADDR_W-1:0] a);
        f2i_dec_t d;
        d.idx = a[4:2];
        d.valid = (a[1:0] == 2'h0) && (a[4:2] != 3'h7)
            && (ADDR_W == 5 || a[ADDR_W-1:0] < ADDR_W'(32));
        return d;
    endfunction : f2i_decode

    function automatic logic [31:0] f2i_merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
            if (strb[b])
                r[8*b +: 8] = nw[8*b +: 8];
        return r;
    endfunction : f2i_merge

    function automatic f2i_conv_t f2i_convert(input logic [63:0] s,
        input logic dp, input logic li);
        f2i_conv_t r;
        logic [8:0] t1;
        logic [8:0] t2;
        logic [31:0] mant;
        logic [31:0] mag;
        logic [31:0] ival;
        logic [5:0] w;
        logic [5:0] sh;
        logic msb;
        r = '0;
        w = li ? `F2I_LONG_W : `F2I_SHORT_W;
        // Single source uses only its 23-bit fraction
        mant = dp ? {1'b1, s[54:24]} : {1'b1, s[54:32], 8'h00};
        t1 = {1'b0, s[62:55]} - `F2I_EXP_BIAS1;
        t2 = t1 - (li ? `F2I_LONG_SPAN : `F2I_SHORT_SPAN);
        if (t1[8])
        begin
            r.err = 1'b1;
            r.below_one = 1'b1;
        end
        else if (!t2[8])
            r.err = 1'b1;
        else
        begin
            // t2 of minus one also lands here: sign check decides
            sh = w - 6'(t1) - 6'h01;
            // Shifting drops fraction bits: always truncates
            mag = mant >> (sh + (`F2I_LONG_W - w));
            ival = s[63] ? (32'h0 - mag) : mag;
            if (!li)
                ival = {{16{ival[15]}}, ival[15:0]};
            msb = li ? ival[31] : ival[15];
            r.err = (msb != s[63]);
            r.value = ival;
        end
        return r;
    endfunction : f2i_convert

    // ----------------------------------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------------------------------
    logic aw_full_r;
    logic w_full_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic aw_take;
    logic w_take;
    logic wr_go;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    f2i_dec_t wr_dec;

    assign S_AXI_AWREADY_O = !aw_full_r && !bvalid_r;
    assign S_AXI_WREADY_O = !w_full_r && !bvalid_r;
    assign aw_take = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
    assign w_take = S_AXI_WVALID_I && S_AXI_WREADY_O;
    assign wr_go = (aw_full_r || aw_take) && (w_full_r || w_take);
    assign wr_addr = aw_full_r ? awaddr_r : S_AXI_AWADDR_I;
    assign wr_data = w_full_r ? wdata_r : S_AXI_WDATA_I;
    assign wr_strb = w_full_r ? wstrb_r : S_AXI_WSTRB_I;
    assign wr_dec = f2i_decode(wr_addr);
    assign S_AXI_BVALID_O = bvalid_r;
    assign S_AXI_BRESP_O = bresp_r;

    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= `F2I_RESP_OK;
        end
        else
        begin
            if (wr_go)
            begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_dec.valid ? `F2I_RESP_OK : `F2I_RESP_ERR;
            end
            else
            begin
                if (aw_take)
                begin
                    aw_full_r <= 1'b1;
                    awaddr_r <= S_AXI_AWADDR_I;
                end
                if (w_take)
                begin
                    w_full_r <= 1'b1;
                    wdata_r <= S_AXI_WDATA_I;
                    wstrb_r <= S_AXI_WSTRB_I;
                end
                if (bvalid_r && S_AXI_BREADY_I)
                    bvalid_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    logic cmd_go;
    logic [3:0] op;
    logic st_wr;
    f2i_conv_t conv_now;
    logic [15:0] status_r;
    logic [31:0] src_hi_r;
    logic [31:0] src_lo_r;
    logic [31:0] result_r;
    logic [15:0] iaddr_r;
    logic [3:0] exc_code_r;
    logic [15:0] exc_addr_r;
    logic [31:0] st_merged;
    logic [31:0] ia_merged;

    assign cmd_go = wr_go && wr_dec.valid
        && (wr_addr[4:0] == `F2I_A_CMD) && wr_strb[0];
    assign op = wr_data[3:0];
    assign st_wr = wr_go && wr_dec.valid && (wr_addr[4:0] == `F2I_A_STATUS);
    assign conv_now = f2i_convert({src_hi_r, src_lo_r},
        status_r[`F2I_ST_DP], status_r[`F2I_ST_LI]);
    assign st_merged = f2i_merge({16'h0, status_r}, wr_data, wr_strb);
    assign ia_merged = f2i_merge({16'h0, iaddr_r}, wr_data, wr_strb);

    // ----------------------------------------------------------------
    // Status word
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            status_r <= `F2I_ST_RESET;
        else if (st_wr)
            status_r <= st_merged[15:0];
        else if (cmd_go)
        begin
            case (op)
                `F2I_OP_SINGLE: status_r[`F2I_ST_DP] <= 1'b0;
                `F2I_OP_DOUBLE: status_r[`F2I_ST_DP] <= 1'b1;
                `F2I_OP_SHORTI: status_r[`F2I_ST_LI] <= 1'b0;
                `F2I_OP_LONGI: status_r[`F2I_ST_LI] <= 1'b1;
                `F2I_OP_CONVERT:
                begin
                    // Error flag stays set until software reloads status
                    if (conv_now.err)
                        status_r[`F2I_ST_ERR] <= 1'b1;
                    status_r[`F2I_ST_N] <= conv_now.value[31];
                    status_r[`F2I_ST_Z] <= (conv_now.value == 32'h0)
                        || conv_now.below_one;
                    status_r[`F2I_ST_V] <= 1'b0;
                    status_r[`F2I_ST_C] <= 1'b0;
                end
                default: status_r <= status_r;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Source operand and instruction address
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            src_hi_r <= 32'h0;
            src_lo_r <= 32'h0;
            iaddr_r <= 16'h0;
        end
        else if (wr_go && wr_dec.valid)
        begin
            if (wr_addr[4:0] == `F2I_A_SRC_HI)
                src_hi_r <= f2i_merge(src_hi_r, wr_data, wr_strb);
            if (wr_addr[4:0] == `F2I_A_SRC_LO)
                src_lo_r <= f2i_merge(src_lo_r, wr_data, wr_strb);
            if (wr_addr[4:0] == `F2I_A_IADDR)
                iaddr_r <= ia_merged[15:0];
        end
    end

    // ----------------------------------------------------------------
    // Result and exception registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            result_r <= 32'h0;
            exc_code_r <= 4'h0;
            exc_addr_r <= 16'h0;
        end
        else if (cmd_go && op == `F2I_OP_CONVERT)
        begin
            // Range errors deliver zeros; a failed sign check keeps value
            result_r <= conv_now.value;
            if (conv_now.err)
            begin
                exc_code_r <= `F2I_EC_CONVERT;
                exc_addr_r <= iaddr_r;
            end
        end
        else if (cmd_go && op == `F2I_OP_STEXC)
        begin
            if (wr_data[`F2I_CMD_MEM])
                result_r <= {exc_addr_r, 12'h000, exc_code_r};
            else
                result_r <= {28'h0, exc_code_r};
        end
    end

    // ----------------------------------------------------------------
    // Host condition codes and trap
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            CPU_CC_O <= 4'h0;
            CC_VALID_O <= 1'b0;
            TRAP_O <= 1'b0;
        end
        else
        begin
            CC_VALID_O <= cmd_go && op == `F2I_OP_COPYCC;
            if (cmd_go && op == `F2I_OP_COPYCC)
                CPU_CC_O <= {status_r[`F2I_ST_N], status_r[`F2I_ST_Z],
                    status_r[`F2I_ST_V], status_r[`F2I_ST_C]};
            TRAP_O <= cmd_go && op == `F2I_OP_CONVERT && conv_now.err
                && status_r[`F2I_ST_TRAP_EN];
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------------------------------
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    f2i_dec_t rd_dec;
    logic [31:0] rd_val;

    assign S_AXI_ARREADY_O = !rvalid_r;
    assign S_AXI_RVALID_O = rvalid_r;
    assign S_AXI_RDATA_O = rdata_r;
    assign S_AXI_RRESP_O = rresp_r;
    assign rd_dec = f2i_decode(S_AXI_ARADDR_I);

    always_comb
    begin
        case (S_AXI_ARADDR_I[4:0])
            `F2I_A_STATUS: rd_val = {16'h0, status_r};
            `F2I_A_SRC_HI: rd_val = src_hi_r;
            `F2I_A_SRC_LO: rd_val = src_lo_r;
            `F2I_A_RESULT: rd_val = result_r;
            `F2I_A_IADDR: rd_val = {16'h0, iaddr_r};
            `F2I_A_EXC: rd_val = {exc_addr_r, 12'h000, exc_code_r};
            default: rd_val = 32'h0;
        endcase
    end

    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= `F2I_RESP_OK;
        end
        else if (S_AXI_ARVALID_I && !rvalid_r)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_dec.valid ? rd_val : 32'h0;
            rresp_r <= rd_dec.valid ? `F2I_RESP_OK : `F2I_RESP_ERR;
        end
        else if (rvalid_r && S_AXI_RREADY_I)
            rvalid_r <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    logic cv;
    logic [7:0] ex;
    assign cv = cmd_go && op == `F2I_OP_CONVERT;
    assign ex = src_hi_r[30:23];

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);

    frac_zero_a: assert property (
        cv && ex < 8'h81
        |=> result_r == 32'h0 && status_r[`F2I_ST_Z]
        && status_r[`F2I_ST_ERR])
        else $error("below-one convert not zeroed");
    range_err_a: assert property (
        cv && ex >= (status_r[`F2I_ST_LI] ? 8'hA1 : 8'h91)
        |=> result_r == 32'h0 && status_r[`F2I_ST_ERR])
        else $error("out-of-range convert not flagged");
    in_range_a: assert property (
        cv && !status_r[`F2I_ST_LI] && ex >= 8'h81 && ex < 8'h90
        |=> status_r[`F2I_ST_ERR] == $past(status_r[`F2I_ST_ERR]))
        else $error("in-range convert raised error");
    edge_pos_a: assert property (
        cv && !status_r[`F2I_ST_LI] && ex == 8'h90 && !src_hi_r[31]
        |=> status_r[`F2I_ST_ERR])
        else $error("positive edge value not flagged");
    shift_a: assert property (
        cv && !status_r[`F2I_ST_LI] && ex == 8'h83 && !src_hi_r[31]
        |=> result_r == {29'h0, 1'b1, $past(src_hi_r[22:21])})
        else $error("wrong shift count");
    negate_a: assert property (
        cv && ex == 8'h83 && src_hi_r[31]
        |=> result_r == 32'h0 - {29'h0, 1'b1, $past(src_hi_r[22:21])})
        else $error("negative result not complemented");
    trap_gate_a: assert property (
        cv && conv_now.err
        |=> TRAP_O == $past(status_r[`F2I_ST_TRAP_EN]))
        else $error("trap not tied to enable");
    mode_dp_a: assert property (
        cmd_go && op == `F2I_OP_DOUBLE
        |=> status_r[`F2I_ST_DP] ##1 status_r[`F2I_ST_DP])
        else $error("double mode not set");
    mode_li_a: assert property (
        cmd_go && op == `F2I_OP_SHORTI |=> !status_r[`F2I_ST_LI])
        else $error("short mode not set");
    cc_copy_a: assert property (
        cmd_go && op == `F2I_OP_COPYCC
        |=> CC_VALID_O && CPU_CC_O == $past({status_r[`F2I_ST_N],
        status_r[`F2I_ST_Z], status_r[`F2I_ST_V], status_r[`F2I_ST_C]}))
        else $error("condition codes not copied");
    exc_reg_a: assert property (
        cmd_go && op == `F2I_OP_STEXC && !wr_data[`F2I_CMD_MEM]
        |=> result_r == {28'h0, $past(exc_code_r)})
        else $error("register-mode exception not code only");

    cv_err_c: cover property (cv && conv_now.err ##1 TRAP_O);
    cv_ok_c: cover property (cv && !conv_now.err);
    wr_rd_c: cover property (bvalid_r ##[1:4] rvalid_r);

endmodule : f2i_top

// file: tb/f2i_host_model.sv
// Host processor model: takes conversion traps and condition copies.
// Assumes trap and copy strobes are one-cycle pulses on the clock.
`timescale 1ns/1ps

module f2i_host_model
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic trap_i,
    input wire logic cc_valid_i,
    input wire logic [3:0] cc_i,
    output logic [3:0] cpu_cc_o,
    output logic [8:0] vector_o,
    output int trap_cnt_o
);
    // Trap vector of a floating-point error, octal 244
    localparam logic [8:0] TRAP_VEC = 9'h0A4;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            trap_cnt_o <= 0;
            vector_o <= 9'h000;
        end
        else if (trap_i)
        begin
            trap_cnt_o <= trap_cnt_o + 1;
            vector_o <= TRAP_VEC;
        end
    end

    // Copy lands in the host flags only on the strobe, never in between
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            cpu_cc_o <= 4'h0;
        else if (cc_valid_i)
            cpu_cc_o <= cc_i;
    end
endmodule : f2i_host_model

// file: tb/f2i_top_test.sv
// Self-checking bench of the convert and status block over AXI4-Lite.
// Assumes the defines header and the package are compiled first.
`timescale 1ns/1ps
`include "f2i_defines.svh"

module f2i_top_test;
    import f2i_pkg::*;
    logic clk, nrst, awvalid, wvalid, bready, arvalid, rready;
    logic [4:0] awaddr, araddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic aw_ready, w_ready, bvalid, ar_ready, rvalid, cc_valid, trap;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] cpu_cc, host_cc;
    logic [8:0] vec;
    int trap_cnt, n_mismatch, num_checks, cycles;

    f2i_top DUT (.CLK_I(clk), .NRST_I(nrst), .S_AXI_AWADDR_I(awaddr),
        .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(aw_ready),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb),
        .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(w_ready),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
        .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
        .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(ar_ready),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
        .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
        .CPU_CC_O(cpu_cc), .CC_VALID_O(cc_valid), .TRAP_O(trap));

    f2i_host_model HOST (.clk_i(clk), .nrst_i(nrst), .trap_i(trap),
        .cc_valid_i(cc_valid), .cc_i(cpu_cc), .cpu_cc_o(host_cc),
        .vector_o(vec), .trap_cnt_o(trap_cnt));

    initial
    begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end

    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    // Ready is sampled mid-cycle: it only moves on rising edges
    task automatic wr(input logic [4:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do
        begin
            @(negedge clk);
            ta = awvalid && aw_ready;
            tw = wvalid && w_ready;
            tb = bvalid;
            r = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
        end while (!tb);
        bready <= 1'h0;
        check("bresp", {30'h0, r}, {30'h0, er});
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [1:0] er,
        input logic [31:0] exp, input string name);
        logic ta, tr;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
        begin
            @(negedge clk);
            ta = arvalid && ar_ready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'h0;
        end while (!tr);
        rready <= 1'h0;
        check("rresp", {30'h0, r}, {30'h0, er});
        check(name, d, exp);
    endtask : rd

    function automatic logic [31:0] ref_conv(input logic [31:0] hi,
        input logic [31:0] lo, input logic dp, input logic li,
        output logic err);
        int e;
        int w;
        logic [55:0] m;
        logic [31:0] v;
        e = int'(hi[30:23]) - 128;
        w = li ? 32 : 16;
        err = 1'h0;
        if (e < 1 || e > w)
        begin
            err = 1'h1;
            return 32'h0;
        end
        m = {1'h1, hi[22:0], dp ? lo[31:24] : 8'h00, 24'h0} >> (56 - e);
        v = hi[31] ? -m[31:0] : m[31:0];
        if (!li) v = {{16{v[15]}}, v[15:0]};
        if (v[31] != hi[31]) err = 1'h1;
        return v;
    endfunction : ref_conv

    task automatic do_conv(input logic [31:0] hi, input logic [31:0] lo,
        input logic [15:0] st);
        logic err;
        logic [31:0] v;
        int t0;
        v = ref_conv(hi, lo, st[`F2I_ST_DP], st[`F2I_ST_LI], err);
        wr(`F2I_A_STATUS, {16'h0, st}, 4'hF, `F2I_RESP_OK);
        wr(`F2I_A_SRC_HI, hi, 4'hF, `F2I_RESP_OK);
        wr(`F2I_A_SRC_LO, lo, 4'hF, `F2I_RESP_OK);
        t0 = trap_cnt;
        wr(`F2I_A_CMD, {28'h0, `F2I_OP_CONVERT}, 4'hF, `F2I_RESP_OK);
        rd(`F2I_A_RESULT, `F2I_RESP_OK, v, "result");
        rd(`F2I_A_STATUS, `F2I_RESP_OK, {16'h0, err, st[14:4], v[31],
            v == 32'h0, 2'h0}, "status");
        check("traps", trap_cnt - t0, {31'h0, err && st[10]});
    endtask : do_conv

    task automatic t_short;
        logic [31:0] hv [6] = '{32'h41C0_0000, 32'h4000_0000,
            32'h4880_0000, 32'h4800_0000, 32'hC800_0000, 32'hC1D8_0000};
        // Trap enabled, truncate flag set to show it has no effect
        foreach (hv[i]) do_conv(hv[i], 32'hFFFF_FFFF, 16'h0420);
        check("vector", {23'h0, vec}, 32'h0A4);
    endtask : t_short

    task automatic t_long;
        logic [31:0] hv [5] = '{32'h4F80_0001, 32'h5000_0000,
            32'hD000_0000, 32'h5080_0000, 32'h4C00_0001};
        logic [15:0] sv [5] = '{16'h00C0, 16'h00C0, 16'h00C0,
            16'h00C0, 16'h0040};
        foreach (hv[i]) do_conv(hv[i], 32'h8000_0000, sv[i]);
    endtask : t_long

    task automatic t_modes;
        logic [3:0] op [4] = '{`F2I_OP_DOUBLE, `F2I_OP_LONGI,
            `F2I_OP_SINGLE, `F2I_OP_SHORTI};
        logic [31:0] ex [4] = '{32'h80, 32'hC0, 32'h40, 32'h00};
        wr(`F2I_A_STATUS, 32'h0, 4'hF, `F2I_RESP_OK);
        foreach (op[i])
        begin
            wr(`F2I_A_CMD, {28'h0, op[i]}, 4'hF, `F2I_RESP_OK);
            rd(`F2I_A_STATUS, `F2I_RESP_OK, ex[i],
                "mode");
        end
    endtask : t_modes

    task automatic t_status;
        rd(`F2I_A_STATUS, `F2I_RESP_OK, 32'h0, "status reset");
        wr(`F2I_A_STATUS, 32'hFFFF_84E5, 4'hF, `F2I_RESP_OK);
        rd(`F2I_A_STATUS, `F2I_RESP_OK, 32'h84E5, "status");
        wr(5'h1C, 32'h1, 4'hF, `F2I_RESP_ERR);
        rd(5'h1C, `F2I_RESP_ERR, 32'h0, "unmapped");
    endtask : t_status

    // Exception is read only after a conversion error
    task automatic t_exc;
        wr(`F2I_A_IADDR, 32'h1234, 4'hF, `F2I_RESP_OK);
        do_conv(32'h4000_0000, 32'h0, 16'h0400);
        wr(`F2I_A_CMD, {28'h0, `F2I_OP_STEXC}, 4'hF, `F2I_RESP_OK);
        rd(`F2I_A_RESULT, `F2I_RESP_OK, 32'h6, "exc reg");
        wr(`F2I_A_CMD, 32'h107, 4'hF, `F2I_RESP_OK);
        rd(`F2I_A_RESULT, `F2I_RESP_OK, 32'h1234_0006,
            "exc mem");
    endtask : t_exc

    task automatic t_copy;
        logic [3:0] cv [2] = '{4'hA, 4'h5};
        foreach (cv[i])
        begin
            wr(`F2I_A_STATUS, {28'h0, cv[i]}, 4'hF, `F2I_RESP_OK);
            wr(`F2I_A_CMD, {28'h0, `F2I_OP_COPYCC}, 4'hF, `F2I_RESP_OK);
            @(negedge clk);
            check("host cc", {28'h0, host_cc}, {28'h0, cv[i]});
        end
    endtask : t_copy

    // A hang is cut short well beyond the few hundred cycles needed
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end

    initial
    begin
        nrst = 1'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 5'h00;
        araddr = 5'h00;
        wdata = 32'h0;
        wstrb = 4'h0;
        repeat (16) @(posedge clk);
        nrst <= 1'h1;
        t_status();
        t_modes();
        t_short();
        t_long();
        t_exc();
        t_copy();
        end_of_test();
    end
endmodule : f2i_top_test
